// ===== src/sllor_regs.sv
// Behaviour
// - with the force bit 15 set, the local multiframe counter loads from bits 14-10, else default.
// - the five-bit start field gives the counter's value after a restart; it still wraps from 1F to 00, so the size stays 32.
// - the upper-lane enable register acts only while bank select bit 5 of register 3 is 1.
// - lane 5 carries identifier 00101 unless enable bit 15 selects bits 12-8 of the 5/6 register.
// - lane 6 carries identifier 00110 unless enable bit 14 selects bits 4-0 of the 5/6 register.
// - lane 7 carries identifier 00111 unless enable bit 13 selects bits 12-8 of the 7/8 register.
// - lane 8 carries identifier 01000 unless enable bit 12 selects bits 4-0 of the 7/8 register.
// - checksum enable bits 11 to 8 pick the forced checksum for lanes 5 to 8, else the computed one.
// - bits 15-8 of the 5/6 checksum register hold the forced checksum of lane 5.
// - bits 7-0 of the 5/6 checksum register hold the forced checksum of lane 6.
// - bits 15-8 of the 7/8 checksum register hold the forced checksum of lane 7.
// - bits 7-0 of the 7/8 checksum register hold the forced checksum of lane 8.
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
module sllor_regs
    import sllor_pkg::*;
(
    input  wire logic                    clk_sys,
    input  wire logic                    resetn,
    input  wire sllor_pkg::sllor_avs_req_t avs_req,
    output logic [sllor_pkg::DATA_W-1:0] avs_readdata,
    output logic                         avs_waitrequest,
    input  wire logic                    mf_restart,
    input  wire logic                    frame_tick,
    input  wire sllor_pkg::sllor_chk_vec_t computed_chk,
    output sllor_pkg::sllor_lane_t       lane5,
    output sllor_pkg::sllor_lane_t       lane6,
    output sllor_pkg::sllor_lane_t       lane7,
    output sllor_pkg::sllor_lane_t       lane8,
    output logic [4:0]                   mf_count
);

    // register storage, reserved bits kept at zero
    logic             bank_sel_reg;
    logic             bank_sel_next;
    logic [REG_W-1:0] mf_ovr_reg;
    logic [REG_W-1:0] mf_ovr_next;
    logic [REG_W-1:0] enables_reg;
    logic [REG_W-1:0] enables_next;
    logic [REG_W-1:0] chk56_reg;
    logic [REG_W-1:0] chk56_next;
    logic [REG_W-1:0] chk78_reg;
    logic [REG_W-1:0] chk78_next;
    logic [REG_W-1:0] ident56_reg;
    logic [REG_W-1:0] ident56_next;
    logic [REG_W-1:0] ident78_reg;
    logic [REG_W-1:0] ident78_next;

    // bus handshake
    sllor_bus_state_t  bus_state_reg;
    sllor_bus_state_t  bus_state_next;
    logic              waitreq_reg;
    logic              waitreq_next;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;

    logic [7:0]       req_index;
    logic             commit_write;
    logic [REG_W-1:0] wmask;
    logic [LANES-1:0] ident_en;
    logic [LANES-1:0] chk_en;
    logic [LANES-1:0][4:0] forced_ident;
    logic [LANES-1:0][7:0] forced_chk;
    sllor_lane_t      lane_vec [LANES];

    // merges write data into a register under byte lanes and a field mask
    function automatic logic [REG_W-1:0] merge16(
        input logic [REG_W-1:0] old_val,
        input logic [DATA_W-1:0] wdata,
        input logic [3:0]        be,
        input logic [REG_W-1:0]  field_mask
    );
        logic [REG_W-1:0] lane_mask;
        lane_mask = {{8{be[1]}}, {8{be[0]}}} & field_mask;
        return (old_val & ~lane_mask) | (wdata[REG_W-1:0] & lane_mask);
    endfunction

    // writable field masks; reserved bits never store
    localparam logic [REG_W-1:0] MASK_MF    = 16'hFC00;
    localparam logic [REG_W-1:0] MASK_EN    = 16'hFF00;
    localparam logic [REG_W-1:0] MASK_CHK   = 16'hFFFF;
    localparam logic [REG_W-1:0] MASK_IDENT = 16'h1F1F;

    assign req_index    = avs_req.address[ADDR_W-1:2];
    assign commit_write = avs_req.write && (bus_state_reg == BUS_ANSWER);
    assign wmask        = '0;

    always_comb begin
        bus_state_next = bus_state_reg;
        waitreq_next   = 1'b1;
        rdata_next     = rdata_reg;
        unique case (bus_state_reg)
            BUS_IDLE: begin
                if (avs_req.read || avs_req.write) begin
                    bus_state_next = BUS_ANSWER;
                    waitreq_next   = 1'b0;
                    rdata_next     = '0;
                    if (avs_req.read) begin
                        unique case (req_index)
                            IDX_BANK_SELECT: begin
                                rdata_next[BANK_SEL_BIT] = bank_sel_reg;
                            end
                            IDX_MF_OVERRIDE: begin
                                rdata_next[REG_W-1:0] = mf_ovr_reg;
                            end
                            IDX_UPPER_ENABLES: begin
                                rdata_next[REG_W-1:0] = enables_reg;
                            end
                            IDX_CHK56: begin
                                rdata_next[REG_W-1:0] = chk56_reg;
                            end
                            IDX_CHK78: begin
                                rdata_next[REG_W-1:0] = chk78_reg;
                            end
                            IDX_IDENT56: begin
                                rdata_next[REG_W-1:0] = ident56_reg;
                            end
                            IDX_IDENT78: begin
                                rdata_next[REG_W-1:0] = ident78_reg;
                            end
                            default: begin
                                rdata_next = '0;
                            end
                        endcase
                    end
                end
            end
            BUS_ANSWER: begin
                bus_state_next = BUS_IDLE;
                waitreq_next   = 1'b1;
            end
        endcase
    end

    always_comb begin
        bank_sel_next = bank_sel_reg;
        mf_ovr_next   = mf_ovr_reg;
        enables_next  = enables_reg;
        chk56_next    = chk56_reg;
        chk78_next    = chk78_reg;
        ident56_next  = ident56_reg;
        ident78_next  = ident78_reg;
        if (commit_write) begin
            unique case (req_index)
                IDX_BANK_SELECT: begin
                    if (avs_req.byteenable[0]) begin
                        bank_sel_next = avs_req.writedata[BANK_SEL_BIT];
                    end
                end
                IDX_MF_OVERRIDE: begin
                    mf_ovr_next = merge16(mf_ovr_reg, avs_req.writedata,
                                          avs_req.byteenable, MASK_MF);
                end
                IDX_UPPER_ENABLES: begin
                    enables_next = merge16(enables_reg, avs_req.writedata,
                                           avs_req.byteenable, MASK_EN);
                end
                IDX_CHK56: begin
                    chk56_next = merge16(chk56_reg, avs_req.writedata,
                                         avs_req.byteenable, MASK_CHK);
                end
                IDX_CHK78: begin
                    chk78_next = merge16(chk78_reg, avs_req.writedata,
                                         avs_req.byteenable, MASK_CHK);
                end
                IDX_IDENT56: begin
                    ident56_next = merge16(ident56_reg, avs_req.writedata,
                                           avs_req.byteenable, MASK_IDENT);
                end
                IDX_IDENT78: begin
                    ident78_next = merge16(ident78_reg, avs_req.writedata,
                                           avs_req.byteenable, MASK_IDENT);
                end
                default: begin
                    bank_sel_next = bank_sel_reg;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            bus_state_reg <= BUS_IDLE;
            waitreq_reg   <= 1'b1;
            rdata_reg     <= '0;
            bank_sel_reg  <= 1'b0;
            mf_ovr_reg    <= RST_REG16;
            enables_reg   <= RST_REG16;
            chk56_reg     <= RST_REG16;
            chk78_reg     <= RST_REG16;
            ident56_reg   <= RST_REG16;
            ident78_reg   <= RST_REG16;
        end else begin
            bus_state_reg <= bus_state_next;
            waitreq_reg   <= waitreq_next;
            rdata_reg     <= rdata_next;
            bank_sel_reg  <= bank_sel_next;
            mf_ovr_reg    <= mf_ovr_next;
            enables_reg   <= enables_next;
            chk56_reg     <= chk56_next;
            chk78_reg     <= chk78_next;
            ident56_reg   <= ident56_next;
            ident78_reg   <= ident78_next;
        end
    end

    assign avs_readdata    = rdata_reg;
    assign avs_waitrequest = waitreq_reg;

    // enables gated by bank select
    always_comb begin
        for (int i = 0; i < LANES; i++) begin
            ident_en[i] = bank_sel_reg && enables_reg[IDENT_EN_TOP_BIT-i];
            chk_en[i]   = bank_sel_reg && enables_reg[CHK_EN_TOP_BIT-i];
        end
    end

    // forced values per lane
    assign forced_ident[0] = ident56_reg[HI_IDENT_LO+4:HI_IDENT_LO];
    assign forced_ident[1] = ident56_reg[4:0];
    assign forced_ident[2] = ident78_reg[HI_IDENT_LO+4:HI_IDENT_LO];
    assign forced_ident[3] = ident78_reg[4:0];
    assign forced_chk[0]   = chk56_reg[HI_BYTE_LO+7:HI_BYTE_LO];
    assign forced_chk[1]   = chk56_reg[7:0];
    assign forced_chk[2]   = chk78_reg[HI_BYTE_LO+7:HI_BYTE_LO];
    assign forced_chk[3]   = chk78_reg[7:0];

    localparam logic [LANES-1:0][4:0] DEF_IDENTS = {DEF_IDENT8, DEF_IDENT7,
                                                    DEF_IDENT6, DEF_IDENT5};

    // per-lane identifier and checksum selection
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        sllor_lane_sel #(
            .DEF_IDENT (DEF_IDENTS[g])
        ) u_sel (
            .clk_sys      (clk_sys),
            .resetn       (resetn),
            .ident_en     (ident_en[g]),
            .chk_en       (chk_en[g]),
            .forced_ident (forced_ident[g]),
            .forced_chk   (forced_chk[g]),
            .computed_chk (computed_chk[g]),
            .lane_out     (lane_vec[g])
        );
    end

    assign lane5 = lane_vec[0];
    assign lane6 = lane_vec[1];
    assign lane7 = lane_vec[2];
    assign lane8 = lane_vec[3];

    // local multiframe counter
    sllor_mf_counter u_mf (
        .clk_sys     (clk_sys),
        .resetn      (resetn),
        .force_en    (mf_ovr_reg[MF_FORCE_BIT]),
        .start_value (mf_ovr_reg[MF_START_HI:MF_START_LO]),
        .restart     (mf_restart),
        .frame_tick  (frame_tick),
        .count       (mf_count)
    );

endmodule
`default_nettype wire

// ===== src/sllor_pkg.sv
package sllor_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_BANK_SELECT   = 8'h03;
    localparam logic [7:0] IDX_MF_OVERRIDE   = 8'h78;
    localparam logic [7:0] IDX_UPPER_ENABLES = 8'h86;
    localparam logic [7:0] IDX_CHK56         = 8'h87;
    localparam logic [7:0] IDX_CHK78         = 8'h88;
    localparam logic [7:0] IDX_IDENT56       = 8'h89;
    localparam logic [7:0] IDX_IDENT78       = 8'h8A;

    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;
    localparam int REG_W  = 16;
    localparam int LANES  = 4;

    // field positions
    localparam int BANK_SEL_BIT     = 5;
    localparam int MF_FORCE_BIT     = 15;
    localparam int MF_START_HI      = 14;
    localparam int MF_START_LO      = 10;
    localparam int IDENT_EN_TOP_BIT = 15;
    localparam int CHK_EN_TOP_BIT   = 11;
    localparam int HI_IDENT_LO      = 8;
    localparam int HI_BYTE_LO       = 8;

    // reset values
    localparam logic [15:0] RST_REG16 = 16'h0000;
    localparam logic [4:0]  RST_COUNT = 5'h00;
    localparam logic [7:0]  RST_CHK   = 8'h00;

    // default identifiers of lanes 5 to 8
    localparam logic [4:0] DEF_IDENT5 = 5'h05;
    localparam logic [4:0] DEF_IDENT6 = 5'h06;
    localparam logic [4:0] DEF_IDENT7 = 5'h07;
    localparam logic [4:0] DEF_IDENT8 = 5'h08;

    // last state of the local multiframe counter before wrap
    localparam logic [4:0] MF_LAST = 5'h1F;
    localparam logic [4:0] MF_ONE  = 5'h01;

    typedef struct packed {
        logic [ADDR_W-1:0] address;
        logic              read;
        logic              write;
        logic [DATA_W-1:0] writedata;
        logic [3:0]        byteenable;
    } sllor_avs_req_t;

    typedef struct packed {
        logic [4:0] ident;
        logic [7:0] chk;
    } sllor_lane_t;

    typedef logic [LANES-1:0][7:0] sllor_chk_vec_t;
    typedef logic [LANES-1:0]      sllor_lane_out_t;

    typedef enum logic [1:0] {
        BUS_IDLE   = 2'b01,
        BUS_ANSWER = 2'b10
    } sllor_bus_state_t;

endpackage

// ===== src/sllor_lane_sel.sv
`timescale 1ns/1ns
`default_nettype none
module sllor_lane_sel
    import sllor_pkg::*;
#(
    parameter logic [4:0] DEF_IDENT = 5'h00
) (
    input  wire logic         clk_sys,
    input  wire logic         resetn,
    input  wire logic         ident_en,
    input  wire logic         chk_en,
    input  wire logic [4:0]   forced_ident,
    input  wire logic [7:0]   forced_chk,
    input  wire logic [7:0]   computed_chk,
    output sllor_pkg::sllor_lane_t lane_out
);

    sllor_lane_t lane_reg;
    sllor_lane_t lane_next;

    always_comb begin
        lane_next.ident = ident_en ? forced_ident : DEF_IDENT;
        lane_next.chk   = chk_en ? forced_chk : computed_chk;
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            lane_reg <= '0;
        end else begin
            lane_reg <= lane_next;
        end
    end

    assign lane_out = lane_reg;

endmodule
`default_nettype wire

// ===== src/sllor_mf_counter.sv
`timescale 1ns/1ns
`default_nettype none
module sllor_mf_counter
    import sllor_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    input  wire logic       force_en,
    input  wire logic [4:0] start_value,
    input  wire logic       restart,
    input  wire logic       frame_tick,
    output logic [4:0]      count
);

    logic [4:0] count_reg;
    logic [4:0] count_next;

    always_comb begin
        count_next = count_reg;
        if (restart) begin
            count_next = force_en ? start_value : RST_COUNT;
        end else if (frame_tick) begin
            count_next = (count_reg == MF_LAST) ? RST_COUNT : count_reg + MF_ONE;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            count_reg <= RST_COUNT;
        end else begin
            count_reg <= count_next;
        end
    end

    assign count = count_reg;

endmodule
`default_nettype wire

// ===== verif/sllor_rx_model.sv
`timescale 1ns/1ns
`default_nettype none
module sllor_rx_model
    import sllor_pkg::*;
#(
    parameter logic [7:0] CHK_BASE = 8'hA7
) (
    output sllor_pkg::sllor_chk_vec_t computed_chk
);
    // per-lane checksum feed, distinct per lane
    always_comb begin
        for (int i = 0; i < LANES; i++) computed_chk[i] = CHK_BASE + 8'(i * 8'h11);
    end
endmodule
`default_nettype wire

// ===== verif/sllor_regs_sva.sv
`timescale 1ns/1ns
`default_nettype none
module sllor_regs_sva
    import sllor_pkg::*;
(
    input wire logic                      clk_sys,
    input wire logic                      resetn,
    input wire sllor_pkg::sllor_avs_req_t avs_req,
    input wire logic [DATA_W-1:0]         avs_readdata,
    input wire logic                      avs_waitrequest,
    input wire logic                      mf_restart,
    input wire logic                      frame_tick,
    input wire sllor_pkg::sllor_chk_vec_t computed_chk,
    input wire sllor_pkg::sllor_lane_t    lane5,
    input wire sllor_pkg::sllor_lane_t    lane6,
    input wire sllor_pkg::sllor_lane_t    lane7,
    input wire sllor_pkg::sllor_lane_t    lane8,
    input wire logic [4:0]                mf_count
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    logic [15:0] e_reg, c56_reg, c78_reg, i56_reg, i78_reg, mf_reg;
    logic        bank_reg, up_reg, wr_ok;
    logic [7:0]  en;
    function automatic logic [15:0] merge(input logic [15:0] o);
        merge = {avs_req.byteenable[1] ? avs_req.writedata[15:8] : o[15:8],
                 avs_req.byteenable[0] ? avs_req.writedata[7:0] : o[7:0]};
    endfunction
    assign wr_ok = avs_req.write && !avs_waitrequest;
    assign en = bank_reg ? e_reg[15:8] : 8'h00;
    // shadow of the registers from accepted writes
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            {e_reg, c56_reg, c78_reg, i56_reg, i78_reg, mf_reg, bank_reg, up_reg} <= '0;
        end else begin
            up_reg <= 1'b1;
            if (wr_ok) begin
                case (avs_req.address[9:2])
                    IDX_BANK_SELECT: if (avs_req.byteenable[0]) bank_reg <= avs_req.writedata[5];
                    IDX_MF_OVERRIDE: mf_reg <= merge(mf_reg);
                    IDX_UPPER_ENABLES: e_reg <= merge(e_reg);
                    IDX_CHK56: c56_reg <= merge(c56_reg);
                    IDX_CHK78: c78_reg <= merge(c78_reg);
                    IDX_IDENT56: i56_reg <= merge(i56_reg);
                    IDX_IDENT78: i78_reg <= merge(i78_reg);
                    default: ;
                endcase
            end
        end
    end
    chk_wait_answer: assert property ((avs_req.read || avs_req.write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("no answer");
    chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("long answer");
    chk_rd_upper: assert property (!avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
        else $error("upper read bits");
    chk_lane5_ident: assert property (up_reg |-> lane5.ident ==
        $past(en[7] ? i56_reg[12:8] : DEF_IDENT5)) else $error("lane5 ident");
    chk_lane8_ident: assert property (up_reg |-> lane8.ident ==
        $past(en[4] ? i78_reg[4:0] : DEF_IDENT8)) else $error("lane8 ident");
    chk_lane6_chk: assert property (up_reg |-> lane6.chk ==
        $past(en[2] ? c56_reg[7:0] : computed_chk[1])) else $error("lane6 checksum");
    chk_lane7_chk: assert property (up_reg |-> lane7.chk ==
        $past(en[1] ? c78_reg[15:8] : computed_chk[2])) else $error("lane7 checksum");
    chk_mf_reload: assert property (mf_restart |=> mf_count ==
        ($past(mf_reg[15]) ? $past(mf_reg[14:10]) : 5'h00)) else $error("counter reload");
    chk_mf_step: assert property (frame_tick && !mf_restart |=>
        mf_count == $past(mf_count) + 5'h01) else $error("counter step");
endmodule
bind sllor_regs sllor_regs_sva u_sva (.clk_sys(clk_sys), .resetn(resetn), .avs_req(avs_req),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mf_restart(mf_restart),
    .frame_tick(frame_tick), .computed_chk(computed_chk), .lane5(lane5), .lane6(lane6),
    .lane7(lane7), .lane8(lane8), .mf_count(mf_count));
`default_nettype wire

// ===== verif/sllor_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
module sllor_regs_tb;
    import sllor_pkg::*;
    logic              clk_sys = 1'b0;
    logic              resetn = 1'b0;
    logic              mf_restart = 1'b0;
    logic              frame_tick = 1'b0;
    sllor_avs_req_t    req = '0;
    logic [DATA_W-1:0] rdata;
    logic              wait_req;
    sllor_chk_vec_t    cchk;
    sllor_lane_t [3:0] ln;
    logic [4:0]        mf_count;
    logic [31:0]       q;
    int                bad_count = 0;
    int                checks_done = 0;
    logic [7:0]        ix [8] = '{IDX_BANK_SELECT, IDX_MF_OVERRIDE, IDX_UPPER_ENABLES,
        IDX_CHK56, IDX_CHK78, IDX_IDENT56, IDX_IDENT78, 8'h10};
    logic [15:0]       msk [8] = '{16'h0020, 16'hFC00, 16'hFF00, 16'hFFFF, 16'hFFFF,
        16'h1F1F, 16'h1F1F, 16'h0000};
    logic [4:0]        fid [4] = '{5'h1A, 5'h0B, 5'h1C, 5'h0D};
    logic [7:0]        fck [4] = '{8'h33, 8'h44, 8'h55, 8'h66};
    always #4 clk_sys = ~clk_sys;
    sllor_regs DUT (.clk_sys(clk_sys), .resetn(resetn), .avs_req(req), .avs_readdata(rdata),
        .avs_waitrequest(wait_req), .mf_restart(mf_restart), .frame_tick(frame_tick),
        .computed_chk(cchk), .lane5(ln[0]), .lane6(ln[1]), .lane7(ln[2]), .lane8(ln[3]),
        .mf_count(mf_count));
    sllor_rx_model u_rx (.computed_chk(cchk));
    task automatic summarize();
        if (bad_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic [7:0] idx, input logic wr, input logic [15:0] d,
                       input logic [3:0] be);
        int n;
        n = 0;
        req <= '{address: {idx, 2'b00}, read: !wr, write: wr, writedata: {16'h0000, d},
                 byteenable: be};
        @(posedge clk_sys);
        while (wait_req !== 1'b0 && n < 64) begin
            @(posedge clk_sys);
            n++;
        end
        cmp({31'h0, wait_req}, 32'h0);
        q = rdata;
        req.read <= 1'b0;
        req.write <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [15:0] exp);
        bus(idx, 1'b0, 16'h0000, 4'hF);
        cmp(q, {16'h0000, exp});
    endtask
    task automatic lanes(input logic [7:0] en);
        logic [4:0] ei;
        logic [7:0] ec;
        repeat (2) @(posedge clk_sys);
        for (int i = 0; i < 4; i++) begin
            ei = en[7-i] ? fid[i] : 5'(5 + i);
            ec = en[3-i] ? fck[i] : cchk[i];
            cmp({19'h0, ln[i]}, {19'h0, ei, ec});
        end
    endtask
    task automatic step(input logic tick, input logic [4:0] exp);
        if (tick) frame_tick <= 1'b1;
        else mf_restart <= 1'b1;
        @(posedge clk_sys);
        frame_tick <= 1'b0;
        mf_restart <= 1'b0;
        @(posedge clk_sys);
        cmp({27'h0, mf_count}, {27'h0, exp});
    endtask
    task automatic t_reset();
        for (int i = 0; i < 8; i++) rd(ix[i], 16'h0000);
        lanes(8'h00);
        cmp({27'h0, mf_count}, 32'h0);
    endtask
    task automatic t_access();
        for (int i = 0; i < 8; i++) begin
            bus(ix[i], 1'b1, 16'hFFFF, 4'hF);
            rd(ix[i], msk[i]);
        end
        bus(IDX_CHK56, 1'b1, 16'h0000, 4'h2);
        rd(IDX_CHK56, 16'h00FF);
    endtask
    task automatic t_lanes();
        logic [7:0] e;
        bus(IDX_IDENT56, 1'b1, 16'h1A0B, 4'hF);
        bus(IDX_IDENT78, 1'b1, 16'h1C0D, 4'hF);
        bus(IDX_CHK56, 1'b1, 16'h3344, 4'hF);
        bus(IDX_CHK78, 1'b1, 16'h5566, 4'hF);
        bus(IDX_BANK_SELECT, 1'b1, 16'h0000, 4'hF);
        lanes(8'h00);
        bus(IDX_BANK_SELECT, 1'b1, 16'h0020, 4'hF);
        for (int k = 0; k < 9; k++) begin
            e = (k == 8) ? 8'hFF : 8'(1 << k);
            bus(IDX_UPPER_ENABLES, 1'b1, {e, 8'h00}, 4'hF);
            lanes(e);
        end
    endtask
    task automatic t_mf();
        bus(IDX_MF_OVERRIDE, 1'b1, 16'hF800, 4'hF);
        step(1'b0, 5'h1E);
        step(1'b1, 5'h1F);
        step(1'b1, 5'h00);
        bus(IDX_MF_OVERRIDE, 1'b1, 16'h7800, 4'hF);
        step(1'b0, 5'h00);
    endtask
    initial begin
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        t_reset();
        t_access();
        t_lanes();
        t_mf();
        resetn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        t_reset();
        summarize();
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        bad_count++;
        summarize();
    end
endmodule
`default_nettype wire
